// File: rtl/bsd_pkg.sv
/*
 Constants for the brake sequencer and direction selector: register map,
 field layouts, reset values and timing counts.
 Assumes a 10 MHz pclk; one millisecond is derived as a tick from it.
*/
//
// Contract
// - Wait time from servo-off to brake, 0..10000 ms, default 500.
// - Speed threshold for brake after servo-off, 0..1000, default 100.
// - Wait interval counts from received servo-off, then brake engages.
// - Brake decision applies priority between wait and speed conditions; the code engages the brake on either condition alone.
// - Brake function mapped onto a sequence output from reset.
// - Brake output line may be remapped to another output function.
// - One direction bit: 0 forward is clockwise, 1 counterclockwise; default 0.
// - At default, forward is clockwise seen from load side.
// - Changing direction inverts incoming pulse commands, no rewiring.
// - Brake release delayed after servo-on, 0..10000 ms, default 0.
// - Actual servo-off delayed after command, 0..10000 ms, default 0.
package bsd_pkg;
   // ------------------------------------------------------------
   // Register map (byte addresses)
   // ------------------------------------------------------------
   localparam logic [7:0] BSD_WAIT_OFS = 8'h00;
   localparam logic [7:0] BSD_SPD_OFS = 8'h04;
   localparam logic [7:0] BSD_REL_OFS = 8'h08;
   localparam logic [7:0] BSD_SOFF_OFS = 8'h0c;
   localparam logic [7:0] BSD_CFG_OFS = 8'h10;
   localparam logic [7:0] BSD_STAT_OFS = 8'h14;
   // ------------------------------------------------------------
   // Field positions and limits
   // ------------------------------------------------------------
   localparam int BSD_TIME_W = 14;
   localparam int BSD_SPD_W = 10;
   localparam int BSD_CFG_DIR_BIT = 0;
   localparam int BSD_CFG_FUNC_LSB = 4;
   localparam int BSD_FUNC_W = 2;
   localparam logic [13:0] BSD_TIME_MAX = 14'h2710;
   localparam logic [9:0] BSD_SPD_MAX = 10'h3e8;
   // Output function select codes
   localparam logic [1:0] BSD_FUNC_BRAKE = 2'h0;
   localparam logic [1:0] BSD_FUNC_SERVO = 2'h1;
   localparam logic [1:0] BSD_FUNC_LOW = 2'h2;
   localparam logic [1:0] BSD_FUNC_HIGH = 2'h3;
   // ------------------------------------------------------------
   // Reset values
   // ------------------------------------------------------------
   localparam logic [13:0] BSD_WAIT_RST = 14'h01f4;
   localparam logic [9:0] BSD_SPD_RST = 10'h064;
   localparam logic [13:0] BSD_REL_RST = 14'h0000;
   localparam logic [13:0] BSD_SOFF_RST = 14'h0000;
   localparam logic BSD_DIR_RST = 1'b0;
   localparam logic [1:0] BSD_FUNC_RST = BSD_FUNC_BRAKE;
   // ------------------------------------------------------------
   // Timing
   // ------------------------------------------------------------
   localparam int BSD_CLK_HZ = 10000000;
   localparam int BSD_TICK_MS = 1;
   localparam int BSD_TICK_CYC = BSD_CLK_HZ / 1000 * BSD_TICK_MS;
   localparam int BSD_DIV_W = 14;
   // ------------------------------------------------------------
   // Sequencer states
   // ------------------------------------------------------------
   typedef enum logic [3:0] {
      BSD_OFF = 4'b0001,
      BSD_RELWAIT = 4'b0010,
      BSD_ON = 4'b0100,
      BSD_OFFWAIT = 4'b1000
   } bsd_state_e;
endpackage

// File: rtl/bsd_tick.sv
/*
 Millisecond tick divider for the brake sequencer.
 Assumes pclk at the package rate; tick is a one-cycle pulse.
*/
`timescale 1ns/1ps
`default_nettype none
module bsd_tick
   import bsd_pkg::*;
(
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // Tick out
   output logic tick
);
   logic [BSD_DIV_W-1:0] cnt_r, cnt_nxt;
   localparam logic [BSD_DIV_W-1:0] LAST = BSD_DIV_W'(BSD_TICK_CYC - 1);

   always_comb begin
      cnt_nxt = (cnt_r == LAST) ? '0 : cnt_r + 1'b1;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt_r <= '0;
      end else begin
         cnt_r <= cnt_nxt;
      end
   end

   assign tick = (cnt_r == LAST);
endmodule
`default_nettype wire

// File: rtl/bsd_top.sv
/*
 Brake sequencing and rotation direction block with an APB register file.
 Assumes APB3 master on pclk, motor speed magnitude and pulse command
 inputs synchronous to pclk, and the servo-on command already debounced.
*/
// Added by the designer: the register addresses and register access over APB.
`timescale 1ns/1ps
`default_nettype none
module bsd_top
   import bsd_pkg::*;
(
   // APB
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Host command and feedback
   input wire logic servo_on_command,
   input wire logic [BSD_SPD_W-1:0] motor_speed,
   // Pulse command in
   input wire logic cmd_pulse,
   input wire logic cmd_dir,
   // Drive side
   output logic servo_enable,
   output logic pulse_out,
   output logic dir_out,
   output logic brake_output,
   output logic seq_output
);
   // ------------------------------------------------------------
   // Registers
   // ------------------------------------------------------------
   logic [BSD_TIME_W-1:0] brake_wait_time_param_r, brake_wait_time_param_nxt;
   logic [BSD_SPD_W-1:0] brake_speed_threshold_param_r;
   logic [BSD_SPD_W-1:0] brake_speed_threshold_param_nxt;
   logic [BSD_TIME_W-1:0] brake_release_delay_param_r;
   logic [BSD_TIME_W-1:0] brake_release_delay_param_nxt;
   logic [BSD_TIME_W-1:0] servo_off_delay_param_r, servo_off_delay_param_nxt;
   logic direction_select_param_r, direction_select_param_nxt;
   logic [BSD_FUNC_W-1:0] func_sel_r, func_sel_nxt;
   logic [31:0] prdata_r, prdata_nxt;
   logic pslverr_r, pslverr_nxt;
   logic wr_en, rd_en, hit, locked;
   logic [31:0] wdat;

   assign wr_en = psel && penable && pwrite;
   assign rd_en = psel && penable && !pwrite;
   assign pready = 1'b1;
   assign prdata = prdata_r;
   assign pslverr = pslverr_r;

   // ------------------------------------------------------------
   // Sequencer signals
   // ------------------------------------------------------------
   bsd_state_e state_r, state_nxt;
   logic [BSD_TIME_W-1:0] wait_cnt_r, wait_cnt_nxt;
   logic [BSD_TIME_W-1:0] soff_cnt_r, soff_cnt_nxt;
   logic servo_en_r, servo_en_nxt;
   logic brake_r, brake_nxt;
   logic tick, wait_done, speed_low, soff_done;

   // Parameters locked while the servo is on
   assign locked = (state_r != BSD_OFF);
   always_comb begin
      hit = 1'b1;
      unique case (paddr)
         BSD_WAIT_OFS, BSD_SPD_OFS, BSD_REL_OFS, BSD_SOFF_OFS,
         BSD_CFG_OFS, BSD_STAT_OFS: hit = 1'b1;
         default: hit = 1'b0;
      endcase
   end

   assign wdat = pwdata;

   always_comb begin
      brake_wait_time_param_nxt = brake_wait_time_param_r;
      brake_speed_threshold_param_nxt = brake_speed_threshold_param_r;
      brake_release_delay_param_nxt = brake_release_delay_param_r;
      servo_off_delay_param_nxt = servo_off_delay_param_r;
      direction_select_param_nxt = direction_select_param_r;
      func_sel_nxt = func_sel_r;
      prdata_nxt = prdata_r;
      pslverr_nxt = 1'b0;
      if (psel && penable) begin
         // Unmapped accesses or locked writes answer with an error
         pslverr_nxt = !hit || (pwrite && locked);
      end
      if (wr_en && !locked) begin
         unique case (paddr)
            BSD_WAIT_OFS: begin
               // Out of range values saturate to the upper limit
               brake_wait_time_param_nxt =
                  (wdat[31:BSD_TIME_W] != '0 ||
                   wdat[BSD_TIME_W-1:0] > BSD_TIME_MAX) ?
                  BSD_TIME_MAX : wdat[BSD_TIME_W-1:0];
            end
            BSD_SPD_OFS: begin
               brake_speed_threshold_param_nxt =
                  (wdat[31:BSD_SPD_W] != '0 ||
                   wdat[BSD_SPD_W-1:0] > BSD_SPD_MAX) ?
                  BSD_SPD_MAX : wdat[BSD_SPD_W-1:0];
            end
            BSD_REL_OFS: begin
               brake_release_delay_param_nxt =
                  (wdat[31:BSD_TIME_W] != '0 ||
                   wdat[BSD_TIME_W-1:0] > BSD_TIME_MAX) ?
                  BSD_TIME_MAX : wdat[BSD_TIME_W-1:0];
            end
            BSD_SOFF_OFS: begin
               servo_off_delay_param_nxt =
                  (wdat[31:BSD_TIME_W] != '0 ||
                   wdat[BSD_TIME_W-1:0] > BSD_TIME_MAX) ?
                  BSD_TIME_MAX : wdat[BSD_TIME_W-1:0];
            end
            BSD_CFG_OFS: begin
               direction_select_param_nxt = wdat[BSD_CFG_DIR_BIT];
               func_sel_nxt =
                  wdat[BSD_CFG_FUNC_LSB +: BSD_FUNC_W];
            end
            default: begin
            end
         endcase
      end
      if (rd_en) begin
         unique case (paddr)
            BSD_WAIT_OFS: prdata_nxt = 32'(brake_wait_time_param_r);
            BSD_SPD_OFS: prdata_nxt = 32'(brake_speed_threshold_param_r);
            BSD_REL_OFS: prdata_nxt = 32'(brake_release_delay_param_r);
            BSD_SOFF_OFS: prdata_nxt = 32'(servo_off_delay_param_r);
            BSD_CFG_OFS: prdata_nxt =
               32'({func_sel_r, 3'h0, direction_select_param_r});
            BSD_STAT_OFS: prdata_nxt =
               32'({brake_r, servo_en_r, state_r});
            default: prdata_nxt = 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         brake_wait_time_param_r <= BSD_WAIT_RST;
         brake_speed_threshold_param_r <= BSD_SPD_RST;
         brake_release_delay_param_r <= BSD_REL_RST;
         servo_off_delay_param_r <= BSD_SOFF_RST;
         direction_select_param_r <= BSD_DIR_RST;
         func_sel_r <= BSD_FUNC_RST;
         prdata_r <= 32'h0000_0000;
         pslverr_r <= 1'b0;
      end else begin
         brake_wait_time_param_r <= brake_wait_time_param_nxt;
         brake_speed_threshold_param_r <= brake_speed_threshold_param_nxt;
         brake_release_delay_param_r <= brake_release_delay_param_nxt;
         servo_off_delay_param_r <= servo_off_delay_param_nxt;
         direction_select_param_r <= direction_select_param_nxt;
         func_sel_r <= func_sel_nxt;
         prdata_r <= prdata_nxt;
         pslverr_r <= pslverr_nxt;
      end
   end

   // ------------------------------------------------------------
   // Millisecond time base
   // ------------------------------------------------------------
   bsd_tick u_tick (
      .pclk(pclk),
      .presetn(presetn),
      .tick(tick)
   );

   // ------------------------------------------------------------
   // Brake and servo sequencer
   // ------------------------------------------------------------
   // Brake engage: either condition alone suffices, so no ordering
   // between the two can delay the brake.
   assign wait_done = (wait_cnt_r >= brake_wait_time_param_r);
   assign speed_low =
      (motor_speed <= brake_speed_threshold_param_r);
   assign soff_done = (soff_cnt_r >= servo_off_delay_param_r);

   always_comb begin
      state_nxt = state_r;
      wait_cnt_nxt = wait_cnt_r;
      soff_cnt_nxt = soff_cnt_r;
      servo_en_nxt = servo_en_r;
      brake_nxt = brake_r;
      unique case (state_r)
         BSD_OFF: begin
            brake_nxt = 1'b1;
            servo_en_nxt = 1'b0;
            if (servo_on_command) begin
               // Torque first, brake release later
               servo_en_nxt = 1'b1;
               wait_cnt_nxt = '0;
               state_nxt = BSD_RELWAIT;
            end
         end
         BSD_RELWAIT: begin
            if (!servo_on_command) begin
               wait_cnt_nxt = '0;
               soff_cnt_nxt = '0;
               state_nxt = BSD_OFFWAIT;
            end else if (wait_cnt_r >= brake_release_delay_param_r) begin
               brake_nxt = 1'b0;
               state_nxt = BSD_ON;
            end else if (tick) begin
               wait_cnt_nxt = wait_cnt_r + 1'b1;
            end
         end
         BSD_ON: begin
            brake_nxt = 1'b0;
            if (!servo_on_command) begin
               wait_cnt_nxt = '0;
               soff_cnt_nxt = '0;
               state_nxt = BSD_OFFWAIT;
            end
         end
         BSD_OFFWAIT: begin
            if (wait_done || speed_low) begin
               brake_nxt = 1'b1;
            end
            if (soff_done) begin
               servo_en_nxt = 1'b0;
            end
            if (tick && !wait_done) begin
               wait_cnt_nxt = wait_cnt_r + 1'b1;
            end
            if (tick && !soff_done) begin
               soff_cnt_nxt = soff_cnt_r + 1'b1;
            end
            // Servo off completes once both brake and torque are settled
            if ((brake_r || wait_done || speed_low) && soff_done) begin
               brake_nxt = 1'b1;
               servo_en_nxt = 1'b0;
               state_nxt = BSD_OFF;
            end
         end
         default: begin
            brake_nxt = 1'b1;
            servo_en_nxt = 1'b0;
            state_nxt = BSD_OFF;
         end
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_r <= BSD_OFF;
         wait_cnt_r <= '0;
         soff_cnt_r <= '0;
         servo_en_r <= 1'b0;
         brake_r <= 1'b1;
      end else begin
         state_r <= state_nxt;
         wait_cnt_r <= wait_cnt_nxt;
         soff_cnt_r <= soff_cnt_nxt;
         servo_en_r <= servo_en_nxt;
         brake_r <= brake_nxt;
      end
   end

   // ------------------------------------------------------------
   // Outputs
   // ------------------------------------------------------------
   logic pulse_r, dir_r, seq_r, seq_nxt;

   always_comb begin
      unique case (func_sel_r)
         BSD_FUNC_BRAKE: seq_nxt = brake_nxt;
         BSD_FUNC_SERVO: seq_nxt = servo_en_nxt;
         BSD_FUNC_LOW: seq_nxt = 1'b0;
         BSD_FUNC_HIGH: seq_nxt = 1'b1;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pulse_r <= 1'b0;
         dir_r <= 1'b0;
         seq_r <= 1'b1;
      end else begin
         pulse_r <= cmd_pulse;
         // Default keeps forward as clockwise from the load side
         dir_r <= cmd_dir ^ direction_select_param_r;
         seq_r <= seq_nxt;
      end
   end

   assign pulse_out = pulse_r;
   assign dir_out = dir_r;
   assign brake_output = brake_r;
   assign servo_enable = servo_en_r;
   assign seq_output = seq_r;
endmodule
`default_nettype wire

// File: bench/bsd_checker.sv
/*
 Port checker for bsd_top: shadows accepted writes, asserts sequencing.
 Assumes it is bound to bsd_top and sees only its ports.
*/
`timescale 1ns/1ps
`default_nettype none
module bsd_checker
   import bsd_pkg::*;
(
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // APB
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   // Host, pulse and drive side
   input wire logic servo_on_command,
   input wire logic [BSD_SPD_W-1:0] motor_speed,
   input wire logic cmd_pulse,
   input wire logic cmd_dir,
   input wire logic servo_enable,
   input wire logic pulse_out,
   input wire logic dir_out,
   input wire logic brake_output,
   input wire logic seq_output
);
   // ----------------------------------------
   // Shadow of writes; lags the block by one cycle
   // ----------------------------------------
   logic wr_r, wr_nxt, dir_r, dir_nxt;
   logic [7:0] a_r, a_nxt;
   logic [31:0] d_r, d_nxt;
   logic [9:0] thr_r, thr_nxt;
   logic [1:0] fn_r, fn_nxt;
   always_comb begin
      wr_nxt = psel && penable && pwrite;
      a_nxt = paddr;
      d_nxt = pwdata;
      thr_nxt = thr_r;
      dir_nxt = dir_r;
      fn_nxt = fn_r;
      if (wr_r && !pslverr && a_r == BSD_SPD_OFS) begin
         thr_nxt = (d_r > 32'h3e8) ? BSD_SPD_MAX : d_r[9:0];
      end
      if (wr_r && !pslverr && a_r == BSD_CFG_OFS) begin
         dir_nxt = d_r[0];
         fn_nxt = d_r[5:4];
      end
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wr_r <= 1'b0;
         a_r <= 8'h00;
         d_r <= 32'h0;
         thr_r <= BSD_SPD_RST;
         dir_r <= BSD_DIR_RST;
         fn_r <= BSD_FUNC_RST;
      end else begin
         wr_r <= wr_nxt;
         a_r <= a_nxt;
         d_r <= d_nxt;
         thr_r <= thr_nxt;
         dir_r <= dir_nxt;
         fn_r <= fn_nxt;
      end
   end
   // ----------------------------------------
   // Properties
   // ----------------------------------------
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   property p_sat_w;
      psel && penable && !pwrite && paddr == BSD_WAIT_OFS
         |=> prdata <= 32'h2710;
   endproperty
   a_sat_w: assert property (p_sat_w) else $error("wait above max");
   property p_sat_s;
      psel && penable && !pwrite && paddr == BSD_SPD_OFS
         |=> prdata <= 32'h3e8;
   endproperty
   a_sat_s: assert property (p_sat_s) else $error("speed above max");
   property p_hold;
      servo_on_command && $past(servo_on_command) && !$past(brake_output)
         |-> !brake_output;
   endproperty
   a_hold: assert property (p_hold) else $error("brake while on");
   property p_speed;
      $fell(servo_on_command) ##0 (motor_speed <= thr_r) [*3]
         |=> brake_output;
   endproperty
   a_speed: assert property (p_speed) else $error("slow brake");
   property p_seq;
      (fn_r == BSD_FUNC_HIGH) [*2] |-> seq_output;
   endproperty
   a_seq: assert property (p_seq) else $error("seq not high");
   property p_dir;
      !wr_r && !$past(wr_r) |-> dir_out == ($past(cmd_dir) ^ $past(dir_r));
   endproperty
   a_dir: assert property (p_dir) else $error("dir sense wrong");
   property p_refuse;
      psel && penable && pwrite && servo_enable && paddr != BSD_STAT_OFS
         |=> pslverr;
   endproperty
   a_refuse: assert property (p_refuse) else $error("write taken");
   property p_on;
      $rose(servo_on_command) && !servo_enable && brake_output
         |=> servo_enable;
   endproperty
   a_on: assert property (p_on) else $error("no torque on");
   property p_rel;
      $fell(brake_output) |-> servo_enable && $past(servo_on_command);
   endproperty
   a_rel: assert property (p_rel) else $error("release no torque");
endmodule
bind bsd_top bsd_checker u_chk (.pclk(pclk), .presetn(presetn),
   .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
   .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .servo_on_command(servo_on_command), .motor_speed(motor_speed),
   .cmd_pulse(cmd_pulse), .cmd_dir(cmd_dir), .servo_enable(servo_enable),
   .pulse_out(pulse_out), .dir_out(dir_out), .brake_output(brake_output),
   .seq_output(seq_output));
`default_nettype wire

// File: bench/bsd_host_model.sv
/*
 Host controller model: servo on/off command and speed feedback.
 Assumes the bench says when to switch and which speed to report.
*/
`timescale 1ns/1ps
`default_nettype none
module bsd_host_model (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // Bench requests
   input wire logic want_on,
   input wire logic [9:0] speed_set,
   // To the block
   output logic servo_on_command,
   output logic [9:0] motor_speed
);
   // Speed and command move on one edge, so no glitch in between
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         servo_on_command <= 1'b0;
         motor_speed <= 10'h000;
      end else begin
         servo_on_command <= want_on;
         motor_speed <= speed_set;
      end
   end
endmodule
`default_nettype wire

// File: bench/bsd_tb_top.sv
/*
 Self-checking bench for bsd_top: APB master, host model, pulse stimulus.
 Assumes the 1 ms tick of 10000 cycles is not shortened.
*/
`timescale 1ns/1ps
`default_nettype none
module bsd_tb_top
   import bsd_pkg::*;
;
   logic pclk = 1'b0, presetn = 1'b0;
   logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata;
   logic pready, pslverr, servo_on_command, servo_enable;
   logic cmd_pulse = 1'b0, cmd_dir = 1'b0, want_on = 1'b0, pend = 1'b0;
   logic [9:0] speed_set = 10'h000, motor_speed;
   logic pulse_out, dir_out, brake_output, seq_output, cd, cp;
   logic [33:0] exp_q[$];
   logic [31:0] rst_tab[6] = '{32'h1f4, 32'h64, 32'h0, 32'h0, 32'h0, 32'h21};
   int n_mismatch = 0, num_checks = 0, seed = 79648, n;
   initial forever #50 pclk = ~pclk;
   bsd_top dut (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .servo_on_command(servo_on_command), .motor_speed(motor_speed),
      .cmd_pulse(cmd_pulse), .cmd_dir(cmd_dir), .servo_enable(servo_enable),
      .pulse_out(pulse_out), .dir_out(dir_out), .brake_output(brake_output),
      .seq_output(seq_output));
   bsd_host_model u_host (.pclk(pclk), .presetn(presetn), .want_on(want_on),
      .speed_set(speed_set), .servo_on_command(servo_on_command),
      .motor_speed(motor_speed));
   task automatic final_report();
      $display("checks %0d mismatches %0d", num_checks, n_mismatch);
      if (n_mismatch == 0 && num_checks > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   task automatic chk_bit(input logic got, input logic e, input string m);
      num_checks++;
      if (got !== e) begin
         n_mismatch++;
         $display("ERROR %0t %s", $time, m);
      end
   endtask
   task automatic chk_apb(input logic [33:0] e);
      num_checks++;
      if (pslverr !== e[0] || (e[33] && prdata !== e[32:1])) begin
         n_mismatch++;
         $display("ERROR %0t apb got %h err %b", $time, prdata, pslverr);
      end
   endtask
   // Result of an access shows one cycle after its access edge
   always @(posedge pclk) begin
      if (pend && exp_q.size() > 0) chk_apb(exp_q.pop_front());
      pend <= psel && penable && pready;
   end
   task automatic apb(input logic w, input logic [7:0] a,
         input logic [31:0] d, input logic [31:0] e, input logic er);
      int k;
      exp_q.push_back({!w, e, er});
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      k = 0;
      do begin
         @(posedge pclk);
         k++;
      end while (pready !== 1'b1 && k < 20);
      if (pready !== 1'b1) begin
         n_mismatch++;
         final_report();
      end
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask
   // Bounded wait on servo_enable (sel 1) or brake_output (sel 0)
   task automatic wait_on(input logic sel, input logic v, input int lim);
      n = 0;
      while ((sel ? servo_enable : brake_output) !== v && n < lim) begin
         @(posedge pclk);
         n++;
      end
      if ((sel ? servo_enable : brake_output) !== v) begin
         n_mismatch++;
         final_report();
      end
   endtask
   initial begin
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      for (int i = 0; i < 6; i++)
         apb(1'b0, 8'(i * 4), 32'h0, rst_tab[i], 1'b0);
      chk_bit(seq_output, 1'b1, "seq not brake");
      apb(1'b0, 8'h18, 32'h0, 32'h0, 1'b1);
      apb(1'b1, BSD_WAIT_OFS, 32'h3fff, 32'h0, 1'b0);
      apb(1'b0, BSD_WAIT_OFS, 32'h0, 32'h2710, 1'b0);
      apb(1'b1, BSD_SPD_OFS, 32'h7ff, 32'h0, 1'b0);
      apb(1'b0, BSD_SPD_OFS, 32'h0, 32'h3e8, 1'b0);
      apb(1'b1, BSD_WAIT_OFS, 32'h2, 32'h0, 1'b0);
      apb(1'b1, BSD_SPD_OFS, 32'h32, 32'h0, 1'b0);
      apb(1'b1, BSD_REL_OFS, 32'h1, 32'h0, 1'b0);
      $display("test registers done");
      for (int f = 0; f < 4; f++) begin
         for (int dr = 0; dr < 2; dr++) begin
            apb(1'b1, BSD_CFG_OFS, (f << 4) | dr, 32'h0, 1'b0);
            repeat (4) begin
               cd = 1'($random(seed));
               cp = 1'($random(seed));
               cmd_dir <= cd;
               cmd_pulse <= cp;
               repeat (2) @(posedge pclk);
               chk_bit(dir_out, cd ^ 1'(dr), "dir sense");
               chk_bit(pulse_out, cp, "pulse copy");
               chk_bit(seq_output, 1'(4'h9 >> f), "seq func");
            end
         end
      end
      cmd_dir <= 1'b0;
      apb(1'b1, BSD_CFG_OFS, 32'h10, 32'h0, 1'b0);
      $display("test direction done");
      want_on <= 1'b1;
      wait_on(1'b1, 1'b1, 10);
      chk_bit(brake_output, 1'b1, "brake before torque");
      wait_on(1'b0, 1'b0, 25000);
      chk_bit(n <= 20010, 1'b1, "release late");
      chk_bit(seq_output, 1'b1, "seq not servo");
      apb(1'b1, BSD_WAIT_OFS, 32'h5, 32'h0, 1'b1);
      apb(1'b0, BSD_STAT_OFS, 32'h0, 32'h14, 1'b0);
      speed_set <= 10'h33 + 10'($unsigned($random(seed)) % 950);
      want_on <= 1'b0;
      wait_on(1'b0, 1'b1, 25000);
      chk_bit(n >= 9990 && n <= 20010, 1'b1, "wait time");
      repeat (5) @(posedge pclk);
      apb(1'b0, BSD_STAT_OFS, 32'h0, 32'h21, 1'b0);
      $display("test timed brake done");
      apb(1'b1, BSD_SOFF_OFS, 32'h1, 32'h0, 1'b0);
      apb(1'b0, BSD_SOFF_OFS, 32'h0, 32'h1, 1'b0);
      speed_set <= 10'h032;
      want_on <= 1'b1;
      wait_on(1'b0, 1'b0, 25000);
      want_on <= 1'b0;
      wait_on(1'b0, 1'b1, 6);
      chk_bit(servo_enable, 1'b1, "torque cut early");
      wait_on(1'b1, 1'b0, 10010);
      $display("test speed brake done");
      presetn <= 1'b0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      apb(1'b0, BSD_WAIT_OFS, 32'h0, 32'h1f4, 1'b0);
      chk_bit(brake_output, 1'b1, "brake after reset");
      $display("test second reset done");
      final_report();
   end
endmodule
`default_nettype wire
